// [src/tpc_defines.svh]
`ifndef TPC_DEFINES_SVH
`define TPC_DEFINES_SVH

// register offsets (word indices on the plain port)
`define TPC_ADDR_W 4
`define TPC_OFF_CONTROL 4'h0
`define TPC_OFF_PRESCALE_LOW 4'h1
`define TPC_OFF_PRESCALE_HIGH 4'h2
`define TPC_OFF_PERIOD_LOW 4'h3
`define TPC_OFF_PERIOD_HIGH 4'h4
`define TPC_OFF_COUNTER_LOW 4'h5
`define TPC_OFF_COUNTER_HIGH 4'h6
`define TPC_OFF_IRQ_STATUS 4'h7
`define TPC_OFF_IRQ_MASK 4'h8

// control register fields
`define TPC_CTL_RELOAD_BIT 5
`define TPC_CTL_STOP_BIT 4
`define TPC_CTL_IE_BIT 14

// prescaler register fields
`define TPC_PS_COUNT_MSB 15
`define TPC_PS_COUNT_LSB 8
`define TPC_PS_DIV_MSB 7
`define TPC_PS_DIV_LSB 0

// reset values
`define TPC_RST_DIVIDE 16'h0000
`define TPC_RST_PRESCALE 16'h0000
`define TPC_RST_PERIOD 32'hffff_ffff
`define TPC_RST_COUNTER 32'hffff_ffff

// interrupt status bits
`define TPC_IRQ_ZERO_BIT 0

`endif

// [src/tpc_pkg.sv]
package tpc_pkg;
  typedef logic [15:0] tpc_half_t;
  typedef logic [31:0] tpc_word_t;
endpackage

// [src/tpc_prescaler.sv]
`include "tpc_defines.svh"

module tpc_prescaler
  import tpc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic run_in,
  input wire logic reload_in,
  input wire tpc_half_t divide_in,
  output tpc_half_t count_out,
  output logic tick_out
);

  typedef struct packed {
    tpc_half_t count;
  } tpc_ps_state_t;

  tpc_ps_state_t state;
  tpc_ps_state_t next_state;

  // ****************************************************
  // prescale counter
  // ****************************************************

  // tick when the counter sits at zero while running
  assign tick_out = run_in && (state.count == 16'h0000) && !reload_in;
  assign count_out = state.count;

  // next counter value
  always_comb
  begin
    next_state = state;
    if (reload_in)
    begin
      next_state.count = divide_in;
    end
    else if (run_in)
    begin
      if (state.count != 16'h0000)
      begin
        next_state.count = state.count - 16'h0001;
      end
      else
      begin
        // reload after zero; divide read only here and on a reload request, so a new value waits
        next_state.count = divide_in;
      end
    end
  end

  // state register
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      state.count <= `TPC_RST_PRESCALE;
    end
    else
    begin
      state <= next_state;
    end
  end

endmodule

// [src/tpc_timer.sv]
// Added by the designer: strobed register access and the placing of the registers.
`include "tpc_defines.svh"

module tpc_timer
  import tpc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic [`TPC_ADDR_W-1:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  output logic running_out,
  output logic zero_pulse_out,
  output logic irq_out
);

  // all state of the block except the prescaler count in one struct
  typedef struct packed {
    logic stop;
    logic int_enable;
    tpc_half_t divide;
    tpc_word_t period;
    tpc_word_t counter;
    logic zero_status;
    logic zero_mask;
    logic zero_pulse;
    logic [15:0] rdata;
  } tpc_state_t;

  tpc_state_t state;
  tpc_state_t next_state;
  // prescaler taps and decoded strobes
  tpc_half_t ps_count;
  logic ps_tick;
  logic wr_ctl;
  logic reload_req;
  logic reach_zero;

  // ****************************************************
  // write decode
  // ****************************************************

  assign wr_ctl = wr_in && (addr_in == `TPC_OFF_CONTROL);
  assign reload_req = wr_ctl && wdata_in[`TPC_CTL_RELOAD_BIT];
  // counter arrives at zero on a prescaler tick decrementing from one
  assign reach_zero = ps_tick && !reload_req && (state.counter == 32'h0000_0001);

  // ****************************************************
  // prescaler
  // ****************************************************

  // divide ratio is value plus one
  tpc_prescaler u_prescaler (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .run_in(!state.stop),
    .reload_in(reload_req),
    .divide_in(state.divide),
    .count_out(ps_count),
    .tick_out(ps_tick)
  );

  // ****************************************************
  // next state
  // ****************************************************

  // register writes, counting, flags and read mux
  always_comb
  begin
    next_state = state;
    next_state.zero_pulse = 1'b0;
    next_state.rdata = 16'h0000;

    // ************************************************
    // main counter
    // ************************************************

    // main counter decrement on prescaler tick
    // reload wins over a tick landing in the same cycle
    if (reload_req)
    begin
      next_state.counter = state.period;
    end
    else if (ps_tick)
    begin
      // a count at zero starts the next period
      // decrement main counter; wraps by reload from period at zero
      if (state.counter == 32'h0000_0000)
      begin
        next_state.counter = state.period;
      end
      else
      begin
        next_state.counter = state.counter - 32'h0000_0001;
      end
    end

    // one-cycle pulse as the count lands on zero
    if (reach_zero)
    begin
      next_state.zero_pulse = 1'b1;
    end

    // ************************************************
    // register writes
    // ************************************************

    // register writes; reserved control bits are simply dropped
    if (wr_in)
    begin
      case (addr_in)
        `TPC_OFF_CONTROL:
        begin
          next_state.stop = wdata_in[`TPC_CTL_STOP_BIT];
          next_state.int_enable = wdata_in[`TPC_CTL_IE_BIT];
        end

        `TPC_OFF_PRESCALE_LOW:
        begin
          next_state.divide[7:0] = wdata_in[`TPC_PS_DIV_MSB:`TPC_PS_DIV_LSB];
        end

        `TPC_OFF_PRESCALE_HIGH:
        begin
          next_state.divide[15:8] = wdata_in[`TPC_PS_DIV_MSB:`TPC_PS_DIV_LSB];
        end

        `TPC_OFF_PERIOD_LOW:
        begin
          // no atomic latch; stop before rewriting period
          next_state.period[15:0] = wdata_in;
        end

        `TPC_OFF_PERIOD_HIGH:
        begin
          // upper period half
          next_state.period[31:16] = wdata_in;
        end

        `TPC_OFF_IRQ_MASK:
        begin
          // mask bit for zero event
          next_state.zero_mask = wdata_in[`TPC_IRQ_ZERO_BIT];
        end

        // counter and status are read only here
        default:
        begin
          next_state.stop = state.stop;
        end
      endcase
    end

    // ************************************************
    // read mux
    // ************************************************

    // read mux; data presented the cycle after the strobe
    if (rd_in)
    begin
      case (addr_in)
        `TPC_OFF_CONTROL:
        begin
          // stop flag visible, reload bit reads zero
          next_state.rdata[`TPC_CTL_STOP_BIT] = state.stop;
          next_state.rdata[`TPC_CTL_IE_BIT] = state.int_enable;
        end

        `TPC_OFF_PRESCALE_LOW:
        begin
          next_state.rdata = {ps_count[7:0], state.divide[7:0]};
        end

        `TPC_OFF_PRESCALE_HIGH:
        begin
          next_state.rdata = {ps_count[15:8], state.divide[15:8]};
        end

        `TPC_OFF_PERIOD_LOW:
        begin
          // lower period half
          next_state.rdata = state.period[15:0];
        end

        `TPC_OFF_PERIOD_HIGH:
        begin
          // upper period half
          next_state.rdata = state.period[31:16];
        end

        `TPC_OFF_COUNTER_LOW:
        begin
          // halves may tear while running
          next_state.rdata = state.counter[15:0];
        end

        `TPC_OFF_COUNTER_HIGH:
        begin
          // upper counter half
          next_state.rdata = state.counter[31:16];
        end

        `TPC_OFF_IRQ_STATUS:
        begin
          // value before the clear below
          next_state.rdata[`TPC_IRQ_ZERO_BIT] = state.zero_status;
        end

        `TPC_OFF_IRQ_MASK:
        begin
          // mask readback
          next_state.rdata[`TPC_IRQ_ZERO_BIT] = state.zero_mask;
        end

        // unmapped words read zero
        default:
        begin
          next_state.rdata = 16'h0000;
        end
      endcase
    end

    // ************************************************
    // interrupt status
    // ************************************************

    // sticky status: read clears, but a new event wins over the clear
    if (rd_in && (addr_in == `TPC_OFF_IRQ_STATUS))
    begin
      next_state.zero_status = 1'b0;
    end
    if (reach_zero && state.int_enable)
    begin
      next_state.zero_status = 1'b1;
    end
  end

  // ****************************************************
  // state register
  // ****************************************************

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      // stop flag cleared, timer runs out of reset
      state.stop <= 1'b0;
      state.int_enable <= 1'b0;
      state.divide <= `TPC_RST_DIVIDE;

      // period and counter start at all ones
      state.period <= `TPC_RST_PERIOD;
      state.counter <= `TPC_RST_COUNTER;

      // interrupt side idle
      state.zero_status <= 1'b0;
      state.zero_mask <= 1'b0;
      state.zero_pulse <= 1'b0;
      // read data idle
      state.rdata <= 16'h0000;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************

  // read data straight from the flip-flop
  assign rdata_out = state.rdata;
  // run status is the inverse of the stop flag
  assign running_out = !state.stop;
  // registered, one cycle wide
  assign zero_pulse_out = state.zero_pulse;
  // level interrupt while unmasked status set
  assign irq_out = state.zero_status && state.zero_mask;

endmodule

// [tb/tpc_timer_asserts.sv]
`include "tpc_defines.svh"

module tpc_timer_asserts
  import tpc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic [`TPC_ADDR_W-1:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [15:0] rdata_out,
  input wire logic running_out,
  input wire logic zero_pulse_out,
  input wire logic irq_out
);
  // ****************
  // port checks
  // ****************
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (srst_in);

  // control write decode
  wire logic ctl_wr = wr_in && addr_in == `TPC_OFF_CONTROL;

  // reload while stopped, an idle cycle, then read the prescaler
  sequence reload_then_read;
    ctl_wr && wdata_in[5:4] == 2'b11 ##1 !wr_in ##1 rd_in && addr_in == `TPC_OFF_PRESCALE_LOW;
  endsequence

  // two stopped cycles let an in-flight decrement drain
  sequence held_stopped;
    !running_out [*2];
  endsequence

  chk_stop_write: assert property (
    ctl_wr |=> running_out == !$past(wdata_in[4])) else $error("stop flag write lost");
  chk_ctl_read: assert property (
    rd_in && addr_in == `TPC_OFF_CONTROL |=> rdata_out[5:0] == {1'b0, !running_out, 4'h0})
    else $error("control readback wrong");
  chk_read_idle: assert property (
    rdata_out != 16'h0000 |-> $past(rd_in)) else $error("read data outside read cycle");
  chk_reload_read: assert property (
    reload_then_read |=> rdata_out[15:8] == rdata_out[7:0]) else $error("prescale not reloaded");
  chk_stop_quiet: assert property (
    held_stopped |=> !zero_pulse_out) else $error("pulse while stopped");
  chk_pulse_single: assert property (
    zero_pulse_out |=> !zero_pulse_out) else $error("zero pulse too long");
  chk_irq_rise: assert property (
    $rose(irq_out) |-> zero_pulse_out || $past(wr_in)) else $error("irq without cause");
  chk_irq_clear: assert property (
    rd_in && addr_in == `TPC_OFF_IRQ_STATUS |=> !irq_out || zero_pulse_out)
    else $error("irq not cleared by read");
endmodule

bind tpc_timer tpc_timer_asserts chk_i (.mclk_in(mclk_in), .srst_in(srst_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .running_out(running_out), .zero_pulse_out(zero_pulse_out),
  .irq_out(irq_out));

// [tb/tpc_timer_test.sv]
`include "tpc_defines.svh"

module tpc_timer_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [`TPC_ADDR_W-1:0] addr_in = 4'h0;
  logic [15:0] wdata_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [15:0] rdata_out;
  logic running_out, zero_pulse_out, irq_out;
  int error_cnt = 0;
  int num_checks = 0;
  int n;

  tpc_timer dut (.mclk_in(mclk_in), .srst_in(srst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .running_out(running_out), .zero_pulse_out(zero_pulse_out), .irq_out(irq_out));

  // ****************
  // helpers
  // ****************
  // 100 MHz clock
  always #5 mclk_in = ~mclk_in;

  task chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task results;
    if (error_cnt == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // entered at a rising edge; strobe drops, one idle edge before the next call
  task wr(input logic [3:0] a, input logic [15:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
    @(posedge mclk_in);
  endtask

  // data stands only in the cycle after the strobe, so look mid-cycle
  task rd(input logic [3:0] a, input logic [15:0] e);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    @(negedge mclk_in);
    chk(rdata_out, e);
    @(posedge mclk_in);
  endtask

  // bounded wait for the zero pulse; ends mid-cycle of the pulse
  task wp(output int c);
    c = 0;
    do
    begin
      @(negedge mclk_in);
      c++;
    end while (zero_pulse_out !== 1'b1 && c < 200);
    if (c >= 200)
      error_cnt++;
  endtask

  // ****************
  // tests
  // ****************
  // watchdog well beyond the 130 or so cycles needed
  initial
  begin
    #20000;
    error_cnt++;
    results;
  end

  // main sequence
  initial
  begin
    repeat (5) @(posedge mclk_in);
    srst_in <= 1'b0;
    @(negedge mclk_in);
    chk(running_out, 1);
    @(posedge mclk_in);
    rd(4'h0, 16'h0000);
    rd(4'h1, 16'h0000);
    rd(4'h2, 16'h0000);
    rd(4'hf, 16'h0000);
    wr(4'h0, 16'h0010);
    rd(4'h0, 16'h0010);
    wr(4'h1, 16'hab34);
    rd(4'h1, 16'h0034);
    wr(4'h2, 16'hcd12);
    rd(4'h2, 16'h0012);
    wr(4'h3, 16'h0005);
    wr(4'h4, 16'h0000);
    wr(4'h0, 16'h0030);
    rd(4'h1, 16'h3434);
    rd(4'h2, 16'h1212);
    rd(4'h5, 16'h0005);
    rd(4'h0, 16'h0010);
    repeat (30) @(posedge mclk_in);
    wr(4'h0, 16'h0010);
    rd(4'h5, 16'h0005);
    // divide 3, period 2: pulse every 3 ticks of 4 cycles
    wr(4'h1, 16'h0003);
    wr(4'h2, 16'h0000);
    rd(4'h1, 16'h3403);
    wr(4'h3, 16'h0002);
    wr(4'h8, 16'h0001);
    wr(4'h0, 16'h4020);
    wp(n);
    chk(irq_out, 1);
    wp(n);
    chk(32'(n), 12);
    @(posedge mclk_in);
    rd(4'h7, 16'h0001);
    @(negedge mclk_in);
    chk(irq_out, 0);
    @(posedge mclk_in);
    wr(4'h8, 16'h0000);
    wp(n);
    chk(irq_out, 0);
    @(posedge mclk_in);
    wr(4'h8, 16'h0001);
    @(negedge mclk_in);
    chk(irq_out, 1);
    @(posedge mclk_in);
    wr(4'h0, 16'h0010);
    @(negedge mclk_in);
    chk(running_out, 0);
    @(posedge mclk_in);
    wr(4'h0, 16'h0000);
    @(negedge mclk_in);
    chk(running_out, 1);
    results;
  end
endmodule
